// ==== design/pic_map.svh ====
`ifndef PIC_MAP_SVH
`define PIC_MAP_SVH

// Source counts
`define PIC_NUM_PERIPH 30
`define PIC_NUM_SW 7
`define PIC_NUM_SRC 37
`define PIC_NUM_LEVELS 7

// Levels and priorities
`define PIC_LVL_NMI 3'h7
`define PIC_LVL_REMAP 3'h6
`define PIC_PRIO_REMAP0 4'hf
`define PIC_PRIO_REMAP1 4'he
`define PIC_PRIO_SW 4'h0
`define PIC_PRIO_TOP 8

// Vectors and vector table
`define PIC_VEC_BASE 8'h40
`define PIC_VEC_ENTRIES 103
`define PIC_VEC_STRIDE 4

// Status word fields and reset value
`define PIC_SR_MASK_LSB 8
`define PIC_SR_MASK_MSB 10
`define PIC_SR_SUPER_BIT 13
`define PIC_SR_RESET 16'h2700

// Stack frame layout
`define PIC_FRAME_BYTES 32'h0000_0008
`define PIC_FRAME_PC_OFS 32'h0000_0004
`define PIC_FRAME_FORMAT 4'h4

// Controller window at the top of a 24-bit map
`define PIC_WIN_BASE 24'hff_ffc0
`define PIC_WIN_LSB 6

`endif

// ==== design/pic_pkg.sv ====
`include "pic_map.svh"

package pic_pkg;

  typedef enum logic [2:0] {
    SEQ_RUN,
    SEQ_COPY,
    SEQ_VECTOR,
    SEQ_PUSH_SR,
    SEQ_PUSH_PC,
    SEQ_FETCH
  } pic_seq_t;

  typedef struct packed {
    logic [1:0] en;
    logic [5:0] src1;
    logic [5:0] src0;
  } pic_remap_t;

  typedef struct packed {
    logic [31:0] lw0;
    logic [31:0] lw1;
    logic [31:0] addr0;
    logic [31:0] addr1;
    logic [31:0] handler;
  } pic_frame_t;

  typedef struct packed {
    logic [`PIC_NUM_PERIPH-1:0] sync1;
    logic [`PIC_NUM_PERIPH-1:0] sync2;
    logic [`PIC_NUM_SRC-1:0] prev;
    logic [`PIC_NUM_SRC-1:0] edge_pend;
    pic_seq_t seq;
    logic busy;
    logic [15:0] sr;
    logic [15:0] saved_sr;
    logic [5:0] src;
    logic [2:0] lvl;
    logic [7:0] vec;
    logic [2:0] irq_level;
    logic [7:0] irq_vector;
    logic frame_valid;
    logic [31:0] frame_addr;
    logic [31:0] frame_data;
    logic handler_valid;
    logic [31:0] handler_addr;
    logic ack_valid;
    logic ack_err;
    logic [7:0] ack_vector;
  } pic_state_t;

endpackage

// ==== design/pic_prio_enc.sv ====
`timescale 1ns/100ps

module pic_prio_enc #(
  parameter int N = 37
) (
  // Candidate sources
  input wire logic [N-1:0] pend_i,
  input wire logic [N-1:0][2:0] lvl_i,
  input wire logic [N-1:0][3:0] prio_i,
  // Winner
  output logic any_o,
  output logic [5:0] idx_o,
  output logic [2:0] lvl_o
);

  logic [3:0] best_prio;

  // Highest level wins, then highest priority; ties keep the lower index
  always_comb begin
    any_o = 1'b0;
    idx_o = 6'h00;
    lvl_o = 3'h0;
    best_prio = 4'h0;
    for (int i = 0; i < N; i++) begin
      if (pend_i[i] && (!any_o || lvl_i[i] > lvl_o ||
          (lvl_i[i] == lvl_o && prio_i[i] > best_prio))) begin
        any_o = 1'b1;
        idx_o = 6'(i);
        lvl_o = lvl_i[i];
        best_prio = prio_i[i];
      end
    end
  end

endmodule

// ==== design/pic_frame_gen.sv ====
`timescale 1ns/100ps
`include "pic_map.svh"

module pic_frame_gen (
  // Context of the exception
  input wire logic [7:0] vec_i,
  input wire logic [15:0] sr_i,
  input wire logic [31:0] pc_i,
  input wire logic [31:0] sp_i,
  input wire logic [31:0] vbr_i,
  // Frame words, their addresses and the handler entry
  output pic_pkg::pic_frame_t frame_o
);

  logic [15:0] fv_word;

  // Fault status bits are zero: only interrupts come through here
  assign fv_word = {`PIC_FRAME_FORMAT, 2'h0, vec_i, 2'h0};
  assign frame_o.lw0 = {fv_word, sr_i};
  assign frame_o.lw1 = pc_i;
  assign frame_o.addr0 = sp_i - `PIC_FRAME_BYTES;
  assign frame_o.addr1 = sp_i - `PIC_FRAME_BYTES + `PIC_FRAME_PC_OFS;
  assign frame_o.handler = vbr_i + {22'h0, vec_i, 2'h0};

endmodule

// ==== design/pic_top.sv ====
// Operation
// - Status word holds a 3-bit mask; seven request levels with automatic nesting.
// - Levels rank numerically: level 7 highest, level 1 lowest.
// - Level 7 is non-maskable and edge-recognised, taken even at mask seven.
// - Levels 1 to 6 are maskable and pend only while asserted.
// - Requests at or below the mask are blocked, except level 7.
// - Exception entry: copy status, supervisor, vector, push frame, compute handler.
// - Eight-byte frame: format/vector plus status word, then program counter.
// - Controller answers in a 64-byte window at the top of memory.
// - Encoded level and vector go straight to the core.
// - Thirty peripheral requests plus seven software requests, one per level.
// - Each peripheral request has a fixed level and priority.
// - Up to two sources remap to level 6 above all other level-6 sources.
// - Vector number is 64 plus the source index.
// - Vector table of 103 four-byte entries, relocatable by a base.
// - Software acknowledge reads in the window return the vector that would be taken, else zero.
// - A combinational wake-up follows the raw request inputs.
`timescale 1ns/100ps
`include "pic_map.svh"

module pic_top #(
  parameter int NUM_PERIPH = `PIC_NUM_PERIPH,
  parameter int NUM_SW = `PIC_NUM_SW
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Request sources
  input wire logic [NUM_PERIPH-1:0] periph_req_i,
  input wire logic [NUM_SW-1:0] sw_req_i,
  input wire pic_pkg::pic_remap_t remap_i,
  // Core context
  input wire logic sr_wr_i,
  input wire logic [15:0] sr_wdata_i,
  input wire logic rte_i,
  input wire logic [15:0] rte_sr_i,
  input wire logic [31:0] pc_i,
  input wire logic [31:0] sp_i,
  input wire logic [31:0] vector_table_base_i,
  // Acknowledge read cycle
  input wire logic ack_rd_i,
  input wire logic [23:0] ack_addr_i,
  output logic ack_valid_o,
  output logic ack_err_o,
  output logic [7:0] ack_vector_o,
  // Level and vector to the core
  output logic [2:0] irq_level_o,
  output logic [7:0] irq_vector_o,
  output logic [15:0] processor_status_word_o,
  output logic exc_busy_o,
  // Exception frame and handler
  output logic frame_valid_o,
  output logic [31:0] frame_addr_o,
  output logic [31:0] frame_data_o,
  output logic handler_valid_o,
  output logic [31:0] handler_addr_o,
  // Wake-up
  output logic wake_o
);

  localparam int NSRC = NUM_PERIPH + NUM_SW;

  pic_pkg::pic_state_t s_reg;
  pic_pkg::pic_state_t s_next;

  logic [NSRC-1:0] raw;
  logic [NSRC-1:0] pend;
  logic [NSRC-1:0][2:0] lvl_tab;
  logic [NSRC-1:0][3:0] prio_tab;
  logic best_any;
  logic [5:0] best_idx;
  logic [2:0] best_lvl;
  logic [2:0] cur_mask;
  logic take;
  pic_pkg::pic_frame_t frame;

  // Fixed map: sources spread over seven groups, group 0 at level 7
  function automatic logic [2:0] periph_level(input int idx);
    int grp;
    grp = (idx * `PIC_NUM_LEVELS) / NUM_PERIPH;
    return 3'(`PIC_NUM_LEVELS - grp);
  endfunction

  // Lower index ranks higher inside its group
  function automatic logic [3:0] periph_prio(input int idx);
    int grp;
    int first;
    grp = (idx * `PIC_NUM_LEVELS) / NUM_PERIPH;
    first = (grp * NUM_PERIPH + `PIC_NUM_LEVELS - 1) / `PIC_NUM_LEVELS;
    return 4'(`PIC_PRIO_TOP - (idx - first));
  endfunction

  function automatic logic [7:0] src_vector(input logic [5:0] idx);
    return `PIC_VEC_BASE + {2'h0, idx};
  endfunction

  function automatic logic in_window(input logic [23:0] addr);
    return addr[23:`PIC_WIN_LSB] == 18'(`PIC_WIN_BASE >> `PIC_WIN_LSB);
  endfunction

  // Software requests sit after the peripherals, one per level
  assign raw = {sw_req_i, s_reg.sync2};

  // Level and priority of every source after remapping
  always_comb begin
    for (int i = 0; i < NSRC; i++) begin
      if (i < NUM_PERIPH) begin
        lvl_tab[i] = periph_level(i);
        prio_tab[i] = periph_prio(i);
      end else begin
        lvl_tab[i] = 3'(i - NUM_PERIPH + 1);
        prio_tab[i] = `PIC_PRIO_SW;
      end
      if (remap_i.en[1] && remap_i.src1 == 6'(i)) begin
        lvl_tab[i] = `PIC_LVL_REMAP;
        prio_tab[i] = `PIC_PRIO_REMAP1;
      end
      if (remap_i.en[0] && remap_i.src0 == 6'(i)) begin
        lvl_tab[i] = `PIC_LVL_REMAP;
        prio_tab[i] = `PIC_PRIO_REMAP0;
      end
    end
  end

  // Level 7 pends on its edge, the others follow the request line
  always_comb begin
    for (int i = 0; i < NSRC; i++) begin
      if (lvl_tab[i] == `PIC_LVL_NMI) begin
        pend[i] = s_reg.edge_pend[i];
      end else begin
        pend[i] = raw[i];
      end
    end
  end

  pic_prio_enc #(
    .N(NSRC)
  ) u_enc (
    .pend_i(pend),
    .lvl_i(lvl_tab),
    .prio_i(prio_tab),
    .any_o(best_any),
    .idx_o(best_idx),
    .lvl_o(best_lvl)
  );

  assign cur_mask = s_reg.sr[`PIC_SR_MASK_MSB:`PIC_SR_MASK_LSB];

  // Level 7 ignores the mask; the rest must exceed it
  assign take = best_any && (best_lvl == `PIC_LVL_NMI || best_lvl > cur_mask);

  pic_frame_gen u_frame (
    .vec_i(s_reg.vec),
    .sr_i(s_reg.saved_sr),
    .pc_i(pc_i),
    .sp_i(sp_i),
    .vbr_i(vector_table_base_i),
    .frame_o(frame)
  );

  always_comb begin
    logic [NSRC-1:0] clr;
    clr = '0;
    s_next = s_reg;
    s_next.sync1 = periph_req_i;
    s_next.sync2 = s_reg.sync1;
    s_next.prev = raw;
    s_next.frame_valid = 1'b0;
    s_next.handler_valid = 1'b0;
    s_next.ack_valid = 1'b0;
    s_next.ack_err = 1'b0;

    // Encoded request straight to the core, zero when idle
    s_next.irq_level = best_any ? best_lvl : 3'h0;
    s_next.irq_vector = best_any ? src_vector(best_idx) : 8'h00;

    // Acknowledge read consumes an edge request like a vectored take
    if (ack_rd_i) begin
      s_next.ack_valid = 1'b1;
      s_next.ack_err = !in_window(ack_addr_i);
      s_next.ack_vector = 8'h00;
      if (in_window(ack_addr_i) && take) begin
        s_next.ack_vector = src_vector(best_idx);
        clr[best_idx] = 1'b1;
      end
    end

    unique case (s_reg.seq)
      pic_pkg::SEQ_RUN: begin
        if (take && !(ack_rd_i && in_window(ack_addr_i))) begin
          s_next.src = best_idx;
          s_next.lvl = best_lvl;
          s_next.seq = pic_pkg::SEQ_COPY;
        end else if (rte_i) begin
          s_next.sr = rte_sr_i;
        end else if (sr_wr_i) begin
          s_next.sr = sr_wdata_i;
        end
      end
      pic_pkg::SEQ_COPY: begin
        // Mask rises to the taken level so only higher ones, or another level 7, nest
        s_next.saved_sr = s_reg.sr;
        s_next.sr[`PIC_SR_SUPER_BIT] = 1'b1;
        s_next.sr[`PIC_SR_MASK_MSB:`PIC_SR_MASK_LSB] = s_reg.lvl;
        s_next.seq = pic_pkg::SEQ_VECTOR;
      end
      pic_pkg::SEQ_VECTOR: begin
        s_next.vec = src_vector(s_reg.src);
        clr[s_reg.src] = 1'b1;
        s_next.seq = pic_pkg::SEQ_PUSH_SR;
      end
      pic_pkg::SEQ_PUSH_SR: begin
        s_next.frame_valid = 1'b1;
        s_next.frame_addr = frame.addr0;
        s_next.frame_data = frame.lw0;
        s_next.seq = pic_pkg::SEQ_PUSH_PC;
      end
      pic_pkg::SEQ_PUSH_PC: begin
        s_next.frame_valid = 1'b1;
        s_next.frame_addr = frame.addr1;
        s_next.frame_data = frame.lw1;
        s_next.seq = pic_pkg::SEQ_FETCH;
      end
      pic_pkg::SEQ_FETCH: begin
        s_next.handler_valid = 1'b1;
        s_next.handler_addr = frame.handler;
        s_next.seq = pic_pkg::SEQ_RUN;
      end
      default: begin
        s_next.seq = pic_pkg::SEQ_RUN;
      end
    endcase
    s_next.busy = s_next.seq != pic_pkg::SEQ_RUN;

    // A fresh edge in the clearing cycle survives
    s_next.edge_pend = (s_reg.edge_pend & ~clr) | (raw & ~s_reg.prev);
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.seq <= pic_pkg::SEQ_RUN;
      s_reg.sr <= `PIC_SR_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign ack_valid_o = s_reg.ack_valid;
  assign ack_err_o = s_reg.ack_err;
  assign ack_vector_o = s_reg.ack_vector;
  assign irq_level_o = s_reg.irq_level;
  assign irq_vector_o = s_reg.irq_vector;
  assign processor_status_word_o = s_reg.sr;
  assign exc_busy_o = s_reg.busy;
  assign frame_valid_o = s_reg.frame_valid;
  assign frame_addr_o = s_reg.frame_addr;
  assign frame_data_o = s_reg.frame_data;
  assign handler_valid_o = s_reg.handler_valid;
  assign handler_addr_o = s_reg.handler_addr;

  // Unclocked on purpose: must work while the clock is stopped in sleep
  assign wake_o = |periph_req_i || |sw_req_i;

endmodule

// ==== verification/pic_top_assertions.sv ====
`timescale 1ns/100ps
module pic_top_assertions #(
  parameter int NUM_PERIPH = 30,
  parameter int NUM_SW = 7
) (
  // Clock, reset and requests
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [NUM_PERIPH-1:0] periph_req_i,
  input wire logic [NUM_SW-1:0] sw_req_i,
  input wire logic ack_rd_i,
  input wire logic [23:0] ack_addr_i,
  // Controller outputs
  input wire logic ack_valid_o,
  input wire logic ack_err_o,
  input wire logic [7:0] ack_vector_o,
  input wire logic [2:0] irq_level_o,
  input wire logic [7:0] irq_vector_o,
  input wire logic [15:0] processor_status_word_o,
  input wire logic exc_busy_o,
  input wire logic frame_valid_o,
  input wire logic [31:0] frame_addr_o,
  input wire logic [31:0] frame_data_o,
  input wire logic handler_valid_o,
  input wire logic wake_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  property p_frame_seq;
    $rose(frame_valid_o) |=> frame_valid_o ##1 (handler_valid_o && !frame_valid_o);
  endproperty
  a_frame_seq: assert property (p_frame_seq) else $error("bad exception sequence");
  property p_frame_addr;
    $rose(frame_valid_o) |=> frame_addr_o == $past(frame_addr_o) + 32'h4;
  endproperty
  a_frame_addr: assert property (p_frame_addr) else $error("bad frame address");
  property p_frame_fmt;
    $rose(frame_valid_o) |-> frame_data_o[31:28] == 4'h4 && frame_data_o[17:16] == 2'h0;
  endproperty
  a_frame_fmt: assert property (p_frame_fmt) else $error("bad format word");
  property p_busy_sv;
    $rose(frame_valid_o) |-> exc_busy_o && processor_status_word_o[13];
  endproperty
  a_busy_sv: assert property (p_busy_sv) else $error("not busy or not supervisor");
  property p_ack_valid;
    ack_rd_i |=> ack_valid_o;
  endproperty
  a_ack_valid: assert property (p_ack_valid) else $error("missing ack answer");
  property p_ack_err;
    ack_rd_i && ack_addr_i < 24'hff_ffc0 |=> ack_err_o && ack_vector_o == 8'h00;
  endproperty
  a_ack_err: assert property (p_ack_err) else $error("outside ack not refused");
  property p_ack_none;
    !$past(ack_rd_i) |-> !ack_valid_o && !ack_err_o;
  endproperty
  a_ack_none: assert property (p_ack_none) else $error("spurious ack answer");
  property p_wake;
    wake_o == ((|periph_req_i) || (|sw_req_i));
  endproperty
  a_wake: assert property (p_wake) else $error("wake does not follow requests");
  property p_vec_range;
    irq_vector_o != 8'h00 |-> irq_vector_o >= 8'h40 && irq_vector_o <= 8'h64;
  endproperty
  a_vec_range: assert property (p_vec_range) else $error("vector out of range");
  property p_lvl_vec;
    (irq_level_o == 3'h0) == (irq_vector_o == 8'h00);
  endproperty
  a_lvl_vec: assert property (p_lvl_vec) else $error("level and vector disagree");
endmodule

bind pic_top pic_top_assertions #(.NUM_PERIPH(NUM_PERIPH), .NUM_SW(NUM_SW)) chk_u (
  .mclk_i(mclk_i), .rst_i(rst_i), .periph_req_i(periph_req_i), .sw_req_i(sw_req_i),
  .ack_rd_i(ack_rd_i), .ack_addr_i(ack_addr_i), .ack_valid_o(ack_valid_o),
  .ack_err_o(ack_err_o), .ack_vector_o(ack_vector_o), .irq_level_o(irq_level_o),
  .irq_vector_o(irq_vector_o), .processor_status_word_o(processor_status_word_o),
  .exc_busy_o(exc_busy_o), .frame_valid_o(frame_valid_o), .frame_addr_o(frame_addr_o),
  .frame_data_o(frame_data_o), .handler_valid_o(handler_valid_o), .wake_o(wake_o));

// ==== verification/pic_core_model.sv ====
`timescale 1ns/100ps
module pic_core_model #(
  parameter int RET_DLY = 12
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Exception activity
  input wire logic frame_valid_i,
  input wire logic [31:0] frame_data_i,
  input wire logic handler_valid_i,
  // Core context
  output logic rte_o,
  output logic [15:0] rte_sr_o,
  output logic [31:0] pc_o,
  output logic [31:0] sp_o,
  output logic [31:0] vbr_o
);
  logic [7:0] cnt_reg;
  // Fixed context keeps every expectation a constant
  assign pc_o = 32'h0000_1234;
  assign sp_o = 32'h0000_8000;
  assign vbr_o = 32'h0001_0000;
  // Only the latest entry is returned from; deeper nesting is left to the bench
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= 8'h00;
      rte_o <= 1'b0;
      rte_sr_o <= 16'h2700;
    end else begin
      rte_o <= (cnt_reg == 8'h01);
      if (handler_valid_i) begin
        cnt_reg <= RET_DLY[7:0];
      end else if (cnt_reg != 8'h00) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
      if (frame_valid_i && frame_data_i[31:28] == 4'h4) begin
        rte_sr_o <= frame_data_i[15:0];
      end
    end
  end
endmodule

// ==== verification/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [29:0] periph_req_i = 30'h0;
  logic [6:0] sw_req_i = 7'h0;
  pic_pkg::pic_remap_t remap_i = 14'h0;
  logic sr_wr_i = 1'b0;
  logic [15:0] sr_wdata_i = 16'h0;
  logic ack_rd_i = 1'b0;
  logic [23:0] ack_addr_i = 24'h0;
  logic rte_i, ack_valid_o, ack_err_o, exc_busy_o, frame_valid_o, handler_valid_o, wake_o;
  logic [15:0] rte_sr_i, psw_o;
  logic [31:0] pc_i, sp_i, vbr_i, frame_addr_o, frame_data_o, handler_addr_o;
  logic [7:0] ack_vector_o, irq_vector_o;
  logic [2:0] irq_level_o;
  int err_count = 0;
  int checks_done = 0;
  always #5 mclk_i = ~mclk_i;
  pic_top dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .periph_req_i(periph_req_i),
    .sw_req_i(sw_req_i), .remap_i(remap_i), .sr_wr_i(sr_wr_i), .sr_wdata_i(sr_wdata_i),
    .rte_i(rte_i), .rte_sr_i(rte_sr_i), .pc_i(pc_i), .sp_i(sp_i),
    .vector_table_base_i(vbr_i), .ack_rd_i(ack_rd_i), .ack_addr_i(ack_addr_i),
    .ack_valid_o(ack_valid_o), .ack_err_o(ack_err_o), .ack_vector_o(ack_vector_o),
    .irq_level_o(irq_level_o), .irq_vector_o(irq_vector_o),
    .processor_status_word_o(psw_o), .exc_busy_o(exc_busy_o),
    .frame_valid_o(frame_valid_o), .frame_addr_o(frame_addr_o),
    .frame_data_o(frame_data_o), .handler_valid_o(handler_valid_o),
    .handler_addr_o(handler_addr_o), .wake_o(wake_o));
  pic_core_model model_u (.mclk_i(mclk_i), .rst_i(rst_i), .frame_valid_i(frame_valid_o),
    .frame_data_i(frame_data_o), .handler_valid_i(handler_valid_o), .rte_o(rte_i),
    .rte_sr_o(rte_sr_i), .pc_o(pc_i), .sp_o(sp_i), .vbr_o(vbr_i));
  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wait_clk(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task set_sr(input logic [15:0] v);
    @(posedge mclk_i);
    sr_wr_i <= 1'b1;
    sr_wdata_i <= v;
    @(posedge mclk_i);
    sr_wr_i <= 1'b0;
  endtask
  task expect_take(input logic [7:0] vec, input logic [15:0] sr);
    int n;
    n = 0;
    while (frame_valid_o !== 1'b1 && n < 60) begin
      wait_clk(1);
      n++;
    end
    chk("frame_seen", frame_valid_o, 1'b1);
    if (frame_valid_o !== 1'b1) wrap_up();
    chk("busy", exc_busy_o, 1'b1);
    chk("frame_addr0", frame_addr_o, sp_i - 32'h8);
    chk("frame_lw0", frame_data_o, {4'h4, 2'h0, vec, 2'h0, sr});
    wait_clk(1);
    chk("frame_addr1", frame_addr_o, sp_i - 32'h4);
    chk("frame_lw1", frame_data_o, pc_i);
    wait_clk(1);
    chk("handler_valid", handler_valid_o, 1'b1);
    chk("busy_end", exc_busy_o, 1'b0);
    chk("handler", handler_addr_o, vbr_i + {22'h0, vec, 2'h0});
  endtask
  task t_reset;
    wait_clk(1);
    chk("psw_reset", psw_o, 16'h2700);
    chk("level_reset", irq_level_o, 3'h0);
  endtask
  task t_levels;
    for (int k = 0; k < 6; k++) begin
      @(posedge mclk_i);
      sw_req_i <= 7'h1 << k;
      wait_clk(2);
      chk("sw_level", irq_level_o, k + 1);
      chk("sw_vector", irq_vector_o, 8'h5e + k);
      chk("masked", {exc_busy_o, frame_valid_o}, 2'h0);
      chk("wake", wake_o, 1'b1);
    end
    sw_req_i <= 7'h0;
    wait_clk(2);
    chk("level_drop", irq_level_o, 3'h0);
    chk("wake_drop", wake_o, 1'b0);
  endtask
  task t_prio;
    periph_req_i <= 30'h0400_0c00;
    wait_clk(4);
    chk("prio_vector", irq_vector_o, 8'h4a);
    chk("prio_level", irq_level_o, 3'h5);
    periph_req_i <= 30'h0;
    wait_clk(4);
    remap_i <= {2'h3, 6'h0b, 6'h1a};
    periph_req_i <= 30'h0400_0c20;
    wait_clk(4);
    chk("remap0", irq_vector_o, 8'h5a);
    chk("remap0_level", irq_level_o, 3'h6);
    periph_req_i <= 30'h0;
    wait_clk(4);
    remap_i <= {2'h2, 6'h0b, 6'h1a};
    periph_req_i <= 30'h0400_0c20;
    wait_clk(4);
    chk("remap1", irq_vector_o, 8'h4b);
    periph_req_i <= 30'h0;
    wait_clk(4);
    remap_i <= 14'h0;
    chk("periph_drop", irq_level_o, 3'h0);
  endtask
  task t_ack;
    @(posedge mclk_i);
    ack_rd_i <= 1'b1;
    ack_addr_i <= 24'hff_fffc;
    @(posedge mclk_i);
    ack_addr_i <= 24'h00_1000;
    #1;
    chk("ack_valid", ack_valid_o, 1'b1);
    chk("ack_in", {ack_err_o, ack_vector_o}, 9'h000);
    @(posedge mclk_i);
    ack_rd_i <= 1'b0;
    sw_req_i <= 7'h40;
    #1;
    chk("ack_out", {ack_valid_o, ack_err_o, ack_vector_o}, 10'h300);
    // The edge pends one cycle after the request, so the read meets it there
    @(posedge mclk_i);
    ack_rd_i <= 1'b1;
    ack_addr_i <= 24'hff_ffc0;
    @(posedge mclk_i);
    ack_rd_i <= 1'b0;
    #1;
    chk("ack_nmi", {ack_valid_o, ack_err_o, ack_vector_o}, 10'h264);
    wait_clk(8);
    chk("ack_consumed", {exc_busy_o, irq_level_o}, 4'h0);
  endtask
  task t_nest;
    sw_req_i <= 7'h04;
    wait_clk(8);
    chk("mask_blocks", {exc_busy_o, frame_valid_o}, 2'h0);
    set_sr(16'h2200);
    expect_take(8'h60, 16'h2200);
    sw_req_i <= 7'h10;
    expect_take(8'h62, 16'h2300);
    chk("psw_nest", psw_o, 16'h2500);
    sw_req_i <= 7'h0;
    wait_clk(16);
    chk("psw_return", psw_o, 16'h2300);
  endtask
  task t_nmi;
    set_sr(16'h2700);
    sw_req_i <= 7'h40;
    expect_take(8'h64, 16'h2700);
    wait_clk(16);
    chk("nmi_once", {frame_valid_o, irq_level_o}, 4'h0);
    sw_req_i <= 7'h0;
    wait_clk(2);
    chk("psw_nmi", psw_o, 16'h2700);
  endtask
  initial begin
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_reset;
    t_levels;
    t_prio;
    t_ack;
    t_nest;
    t_nmi;
    wrap_up;
  end
endmodule
